// *** resa_fifo.sv ***
// small valid/ready buffer
`timescale 1ns/10ps
module resa_fifo #(
  parameter int W = 19,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  resa_strm_if.snk in_s,
  resa_strm_if.src out_s
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;

  wire push_w = in_s.valid & in_s.ready;
  wire pop_w = out_s.valid & out_s.ready;
  wire [AW-1:0] wp_nxt = (wp_r == LAST) ? '0 : wp_r + 1'b1;
  wire [AW-1:0] rp_nxt = (rp_r == LAST) ? '0 : rp_r + 1'b1;

  assign in_s.ready = (cnt_r != FULL);
  assign out_s.valid = (cnt_r != '0);
  assign out_s.data = mem_r[rp_r];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      if (push_w) begin
        mem_r[wp_r] <= in_s.data;
        wp_r <= wp_nxt;
      end
      if (pop_w) begin
        rp_r <= rp_nxt;
      end
      if (push_w && !pop_w) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop_w && !push_w) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  count_range_a: assert property (@(posedge clk_i) disable iff (rst_i) cnt_r <= FULL)
    else $error("buffer count beyond depth");
endmodule : resa_fifo

// *** resa_i2c_master.sv ***
// two-wire bus master model facing the slave under test
`timescale 1ns/10ps
module resa_i2c_master #(
  parameter int Q_NS = 625
) (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  // data moves a quarter period after the fall, so no false start or stop
  task automatic bit_io(input logic b, output logic s);
    sda_oe_o = ~b;
    #(Q_NS);
    scl_o = 1'b1;
    #(Q_NS);
    s = sda_i;
    #(Q_NS);
    scl_o = 1'b0;
    #(Q_NS);
  endtask : bit_io

  task automatic start();
    sda_oe_o = 1'b1;
    #(Q_NS);
    scl_o = 1'b0;
    #(Q_NS);
  endtask : start

  task automatic rstart();
    sda_oe_o = 1'b0;
    #(Q_NS);
    scl_o = 1'b1;
    #(Q_NS);
    sda_oe_o = 1'b1;
    #(Q_NS);
    scl_o = 1'b0;
    #(Q_NS);
  endtask : rstart

  task automatic stop();
    sda_oe_o = 1'b1;
    #(Q_NS);
    scl_o = 1'b1;
    #(Q_NS);
    sda_oe_o = 1'b0;
    #(2 * Q_NS);
  endtask : stop

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = (s === 1'b0);
  endtask : wr_byte

  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, s);
  endtask : rd_byte
endmodule : resa_i2c_master

// *** resa_pkg.sv ***
// shared types for the two-wire slave access block
package resa_pkg;

  typedef enum {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} resa_st_t;

  typedef enum {PH_ADDR, PH_WADR, PH_WDAT} resa_ph_t;

  // one word to the store: data byte or page commit
  typedef struct packed {
    logic cmt;
    logic [1:0] blk;
    logic [7:0] ptr;
    logic [7:0] dat;
  } resa_ent_t;

endpackage : resa_pkg

// *** resa_regs.svh ***
// constants for the two-wire slave access block
`ifndef RESA_REGS_SVH
`define RESA_REGS_SVH

// address byte fields
`define RESA_CODE_MSB 7
`define RESA_CODE_LSB 4
`define RESA_BLK_MSB 3
`define RESA_BLK_LSB 1
`define RESA_RW_BIT 0

// device code, value is arbitrary
`define RESA_DEV_CODE 4'ha

// block select codes
`define RESA_BLK_CLK 3'h0
`define RESA_BLK_EELO 3'h1
`define RESA_BLK_EEHI 3'h2

// memory geometry
`define RESA_PAGE_BYTES 8
`define RESA_CLK_DEPTH 16
`define RESA_EE_BYTES 512

// reset values
`define RESA_PTR_RST 8'h00
`define RESA_CLK_RST 8'h00
`define RESA_EE_ERASED 8'hff

// timing
`define RESA_MCLK_NS 40
`define RESA_EE_WR_NS 100000
`define RESA_EE_WR_CYC ((`RESA_EE_WR_NS + `RESA_MCLK_NS - 1) / `RESA_MCLK_NS)

`endif

// *** resa_slave.sv ***
// two-wire slave access to clock block and two eeprom blocks
`timescale 1ns/10ps
`include "resa_regs.svh"

// Overview of operation
// - the address byte holds a 4-bit device code, a 3-bit block select and a direction bit, low for write.
// - block select 000 is the clock block, 001 the lower and 010 the upper eeprom block.
// - a write-direction address is acked, then the word address byte loads the pointer and is acked.
// - any number of data bytes may follow, each acked, and STOP ends the write.
// - STOP after an eeprom write starts the internal cycle, during which eeprom addressing gets no ack.
// - eeprom page writes buffer up to 8 bytes and commit after STOP, unwritten bytes unchanged.
// - the pointer increments per written byte and wraps within the 8-byte eeprom page.
// - clock block writes are not page limited and wrap at the end of the block.
// - ack polling gets a nack while the eeprom cycle is busy and an ack once it is done.
// - the clock block stays reachable while an eeprom cycle is running.
// - a current address read returns the byte one past the last accessed address.
// - a random read loads the pointer in the write part before the repeated START.
// - in reads each master ack fetches the next byte and the pointer steps after each byte.
// - reads ignore pages and wrap from the block end to the start of the same block.
// - bytes travel msb first and the receiver acks on the ninth clock.
// - block select bit 1 extends the 8-bit pointer to a 9-bit eeprom word address.
module resa_slave #(
  parameter logic [3:0] DEV_CODE = `RESA_DEV_CODE,
  parameter int CLK_DEPTH = `RESA_CLK_DEPTH,
  parameter int EE_WR_CYCLES = `RESA_EE_WR_CYC
) (
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  output logic EE_BUSY_O
);
  localparam int CW = (CLK_DEPTH > 1) ? $clog2(CLK_DEPTH) : 1;
  localparam int TW = $clog2(EE_WR_CYCLES + 1);
  localparam int PB = `RESA_PAGE_BYTES;
  localparam int EW = $bits(resa_pkg::resa_ent_t);
  localparam logic [8:0] CLK_END = 9'(CLK_DEPTH - 1);
  localparam logic [8:0] CLK_SIZE = 9'(CLK_DEPTH);
  localparam logic [2:0] PG_LAST = 3'(PB - 1);

  // link side: sample data on each rising serial clock
  logic tg_lk_r;
  logic bit_lk_r;

  always_ff @(posedge SCL_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      tg_lk_r <= 1'b0;
      bit_lk_r <= 1'b1;
    end else begin
      tg_lk_r <= ~tg_lk_r;
      bit_lk_r <= SDA_I;
    end
  end

  // synchronisers into the system clock
  logic scl_s1_r, scl_s2_r, scl_d_r;
  logic sda_s1_r, sda_s2_r, sda_d_r;
  logic tg_s1_r, tg_s2_r, tg_d_r;

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r <= 1'b1;
      tg_s1_r <= 1'b0;
      tg_s2_r <= 1'b0;
      tg_d_r <= 1'b0;
    end else begin
      scl_s1_r <= SCL_I;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
      sda_s1_r <= SDA_I;
      sda_s2_r <= sda_s1_r;
      sda_d_r <= sda_s2_r;
      tg_s1_r <= tg_lk_r;
      tg_s2_r <= tg_s1_r;
      tg_d_r <= tg_s2_r;
    end
  end

  wire start_w = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  wire stop_w = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
  wire fall_w = scl_d_r & ~scl_s2_r;
  // bit_lk_r is held stable until the next rising edge, long after the toggle lands
  wire bit_ev_w = tg_s2_r ^ tg_d_r;
  wire cond_w = start_w | stop_w;

  // protocol state
  resa_pkg::resa_st_t st_r;
  resa_pkg::resa_ph_t ph_r;
  logic [7:0] sh_r;
  logic [2:0] cnt_r;
  logic full_r;
  logic [2:0] blk_r;
  logic rw_r;
  logic [7:0] ptr_r;
  logic [7:0] tx_r;
  logic ack_r;
  logic mack_r;
  logic sda_oe_r;
  logic push_v_r;
  resa_pkg::resa_ent_t push_r;
  logic cmt_pend_r;
  logic wr_ee_r;

  // store state
  logic [7:0] clk_mem [CLK_DEPTH];
  logic [7:0] ee_mem [`RESA_EE_BYTES];
  logic [7:0] pbuf_r [PB];
  logic [PB-1:0] pmask_r;
  logic [5:0] ppage_r;
  logic copy_r;
  logic [2:0] cidx_r;
  logic [TW-1:0] tmr_r;
  resa_pkg::resa_ent_t pop_w;

  resa_strm_if #(.W(EW)) wr_s ();
  resa_strm_if #(.W(EW)) rd_s ();

  resa_fifo #(.W(EW), .DEPTH(2)) u_fifo (
    .clk_i(MCLK_I),
    .rst_i(SYS_RST_I),
    .in_s(wr_s),
    .out_s(rd_s)
  );

  assign wr_s.valid = push_v_r;
  assign wr_s.data = push_r;
  assign rd_s.ready = ~copy_r;
  assign pop_w = rd_s.data;
  wire pop_fire_w = rd_s.valid & rd_s.ready;

  // decode of the received byte and the pointer
  wire [3:0] code_w = sh_r[`RESA_CODE_MSB:`RESA_CODE_LSB];
  wire [2:0] bsel_w = sh_r[`RESA_BLK_MSB:`RESA_BLK_LSB];
  wire is_clk_w = (bsel_w == `RESA_BLK_CLK);
  wire is_ee_w = (bsel_w == `RESA_BLK_EELO) || (bsel_w == `RESA_BLK_EEHI);
  wire wr_busy_w = copy_r | (tmr_r != '0);
  wire ee_busy_w = wr_busy_w | cmt_pend_r | push_v_r | rd_s.valid;
  wire adr_ok_w = (code_w == DEV_CODE) && (is_clk_w || (is_ee_w && !ee_busy_w));
  wire blk_clk_w = (blk_r == `RESA_BLK_CLK);
  wire [7:0] clk_next_w = ({1'b0, ptr_r} >= CLK_END) ? 8'h00 : ptr_r + 8'h01;
  wire [7:0] wr_next_w = blk_clk_w ? clk_next_w : {ptr_r[7:3], ptr_r[2:0] + 3'h1};
  wire [7:0] rd_next_w = blk_clk_w ? clk_next_w : ptr_r + 8'h01;
  wire [8:0] eidx_w = {blk_r[1], ptr_r};
  wire [7:0] clk_rd_w = ({1'b0, ptr_r} < CLK_SIZE) ? clk_mem[ptr_r[CW-1:0]] : 8'h00;
  wire [7:0] mem_w = blk_clk_w ? clk_rd_w : ee_mem[eidx_w];
  wire byte_end_w = fall_w & full_r;
  wire slot_free_w = ~push_v_r;
  wire ev_w = byte_end_w & ~cond_w & (st_r == resa_pkg::ST_RX);

  assign SDA_O = 1'b0;
  assign SDA_OE_O = sda_oe_r;
  assign EE_BUSY_O = ee_busy_w;

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      st_r <= resa_pkg::ST_IDLE;
      ph_r <= resa_pkg::PH_ADDR;
      sh_r <= 8'h00;
      cnt_r <= 3'h0;
      full_r <= 1'b0;
      blk_r <= `RESA_BLK_CLK;
      rw_r <= 1'b0;
      ptr_r <= `RESA_PTR_RST;
      tx_r <= 8'h00;
      ack_r <= 1'b0;
      mack_r <= 1'b1;
      sda_oe_r <= 1'b0;
      push_v_r <= 1'b0;
      push_r <= '0;
      cmt_pend_r <= 1'b0;
      wr_ee_r <= 1'b0;
    end else begin
      if (push_v_r && wr_s.ready) begin
        push_v_r <= 1'b0;
      end else if (cmt_pend_r && !push_v_r && !byte_end_w) begin
        push_v_r <= 1'b1;
        push_r <= {1'b1, blk_r[1:0], ptr_r, 8'h00};
        cmt_pend_r <= 1'b0;
      end
      if (cond_w) begin
        if (wr_ee_r) begin
          cmt_pend_r <= 1'b1;
          wr_ee_r <= 1'b0;
        end
        sda_oe_r <= 1'b0;
        full_r <= 1'b0;
        cnt_r <= 3'h0;
        ph_r <= resa_pkg::PH_ADDR;
        st_r <= start_w ? resa_pkg::ST_RX : resa_pkg::ST_IDLE;
      end else begin
        case (st_r)
          resa_pkg::ST_RX: begin
            if (bit_ev_w && !full_r) begin
              sh_r <= {sh_r[6:0], bit_lk_r};
              cnt_r <= cnt_r + 3'h1;
              full_r <= (cnt_r == 3'h7);
            end else if (byte_end_w) begin
              full_r <= 1'b0;
              st_r <= resa_pkg::ST_ACK;
              case (ph_r)
                resa_pkg::PH_ADDR: begin
                  ack_r <= adr_ok_w;
                  sda_oe_r <= adr_ok_w;
                  if (adr_ok_w) begin
                    blk_r <= bsel_w;
                    rw_r <= sh_r[`RESA_RW_BIT];
                  end
                end
                resa_pkg::PH_WADR: begin
                  ack_r <= 1'b1;
                  sda_oe_r <= 1'b1;
                  ptr_r <= sh_r;
                end
                default: begin
                  ack_r <= slot_free_w;
                  sda_oe_r <= slot_free_w;
                  if (slot_free_w) begin
                    push_v_r <= 1'b1;
                    push_r <= {1'b0, blk_r[1:0], ptr_r, sh_r};
                    ptr_r <= wr_next_w;
                    wr_ee_r <= wr_ee_r | ~blk_clk_w;
                  end
                end
              endcase
            end
          end
          resa_pkg::ST_ACK: begin
            if (fall_w) begin
              cnt_r <= 3'h0;
              if (!ack_r) begin
                sda_oe_r <= 1'b0;
                st_r <= resa_pkg::ST_IDLE;
              end else if (ph_r == resa_pkg::PH_ADDR && rw_r) begin
                tx_r <= mem_w;
                sda_oe_r <= ~mem_w[7];
                st_r <= resa_pkg::ST_TX;
              end else begin
                sda_oe_r <= 1'b0;
                st_r <= resa_pkg::ST_RX;
                ph_r <= (ph_r == resa_pkg::PH_ADDR) ? resa_pkg::PH_WADR : resa_pkg::PH_WDAT;
              end
            end
          end
          resa_pkg::ST_TX: begin
            if (fall_w) begin
              if (cnt_r == 3'h7) begin
                sda_oe_r <= 1'b0;
                mack_r <= 1'b1;
                ptr_r <= rd_next_w;
                st_r <= resa_pkg::ST_MACK;
              end else begin
                cnt_r <= cnt_r + 3'h1;
                tx_r <= {tx_r[6:0], 1'b0};
                sda_oe_r <= ~tx_r[6];
              end
            end
          end
          resa_pkg::ST_MACK: begin
            if (bit_ev_w) begin
              mack_r <= bit_lk_r;
            end else if (fall_w) begin
              cnt_r <= 3'h0;
              if (!mack_r) begin
                tx_r <= mem_w;
                sda_oe_r <= ~mem_w[7];
                st_r <= resa_pkg::ST_TX;
              end else begin
                st_r <= resa_pkg::ST_IDLE;
              end
            end
          end
          default: begin
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // store: clock writes land at once, eeprom bytes wait in the page buffer
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      copy_r <= 1'b0;
      cidx_r <= 3'h0;
      pmask_r <= '0;
      ppage_r <= 6'h00;
      tmr_r <= '0;
      for (int i = 0; i < PB; i++) begin
        pbuf_r[i] <= `RESA_EE_ERASED;
      end
      for (int i = 0; i < CLK_DEPTH; i++) begin
        clk_mem[i] <= `RESA_CLK_RST;
      end
      for (int i = 0; i < `RESA_EE_BYTES; i++) begin
        ee_mem[i] <= `RESA_EE_ERASED;
      end
    end else begin
      if (tmr_r != '0) begin
        tmr_r <= tmr_r - 1'b1;
      end
      if (copy_r) begin
        if (pmask_r[cidx_r]) begin
          ee_mem[{ppage_r, cidx_r}] <= pbuf_r[cidx_r];
        end
        cidx_r <= cidx_r + 3'h1;
        if (cidx_r == PG_LAST) begin
          copy_r <= 1'b0;
          pmask_r <= '0;
          tmr_r <= TW'(EE_WR_CYCLES);
        end
      end else if (pop_fire_w) begin
        if (pop_w.cmt) begin
          copy_r <= 1'b1;
          cidx_r <= 3'h0;
        end else if (pop_w.blk == 2'h0) begin
          if ({1'b0, pop_w.ptr} < CLK_SIZE) begin
            clk_mem[pop_w.ptr[CW-1:0]] <= pop_w.dat;
          end
        end else begin
          pbuf_r[pop_w.ptr[2:0]] <= pop_w.dat;
          pmask_r[pop_w.ptr[2:0]] <= 1'b1;
          ppage_r <= {pop_w.blk[1], pop_w.ptr[7:3]};
        end
      end
    end
  end

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);

  code_nack_a: assert property (
    (ev_w && ph_r == resa_pkg::PH_ADDR && code_w != DEV_CODE) |=> !sda_oe_r && !ack_r)
    else $error("foreign device code was acked");
  ee_adr_ack_a: assert property (
    (ev_w && ph_r == resa_pkg::PH_ADDR && code_w == DEV_CODE && is_ee_w && !ee_busy_w)
    |=> sda_oe_r && blk_r == $past(bsel_w))
    else $error("idle eeprom address not acked");
  wadr_load_a: assert property (
    (ev_w && ph_r == resa_pkg::PH_WADR) |=> ptr_r == $past(sh_r) && sda_oe_r)
    else $error("word address not loaded");
  busy_nack_a: assert property (
    (ev_w && ph_r == resa_pkg::PH_ADDR && is_ee_w && ee_busy_w) |=> !sda_oe_r && !ack_r)
    else $error("eeprom acked while busy");
  commit_start_a: assert property (
    (stop_w && wr_ee_r) |=> ee_busy_w ##[1:8] copy_r)
    else $error("page commit did not start after stop");
  page_wrap_a: assert property (
    (ev_w && ph_r == resa_pkg::PH_WDAT && slot_free_w && !blk_clk_w)
    |=> ptr_r[7:3] == $past(ptr_r[7:3]) && ptr_r[2:0] == $past(ptr_r[2:0]) + 3'h1)
    else $error("eeprom write pointer left its page");
  clk_wrap_a: assert property (
    (ev_w && ph_r == resa_pkg::PH_WDAT && slot_free_w && blk_clk_w && {1'b0, ptr_r} == CLK_END)
    |=> ptr_r == 8'h00)
    else $error("clock pointer did not wrap");
  clk_busy_ack_a: assert property (
    (ev_w && ph_r == resa_pkg::PH_ADDR && code_w == DEV_CODE && is_clk_w && ee_busy_w)
    |=> sda_oe_r)
    else $error("clock block refused during eeprom cycle");
  rd_next_a: assert property (
    (st_r == resa_pkg::ST_MACK && fall_w && !mack_r && !bit_ev_w && !cond_w)
    |=> st_r == resa_pkg::ST_TX && sda_oe_r == ~tx_r[7] && cnt_r == 3'h0)
    else $error("master ack did not start next byte");
  rd_wrap_a: assert property (
    (st_r == resa_pkg::ST_TX && fall_w && cnt_r == 3'h7 && !blk_clk_w && !cond_w)
    |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("read pointer step wrong");
  ack_slot_a: assert property (
    (st_r == resa_pkg::ST_ACK && fall_w && !cond_w) |=> st_r != resa_pkg::ST_ACK)
    else $error("acknowledge held past ninth clock");
  wr_time_a: assert property (
    (copy_r && cidx_r == PG_LAST) |=> tmr_r == TW'(EE_WR_CYCLES) ##1 ee_busy_w)
    else $error("write cycle time not loaded");

  ee_page_c: cover property (ev_w && ph_r == resa_pkg::PH_WDAT && !blk_clk_w);
  seq_read_c: cover property (st_r == resa_pkg::ST_MACK && fall_w && !mack_r);
  poll_nack_c: cover property (ev_w && ph_r == resa_pkg::PH_ADDR && is_ee_w && ee_busy_w);
  commit_c: cover property (copy_r && cidx_r == PG_LAST);
endmodule : resa_slave

// *** resa_slave_tb_top.sv ***
// self-checking bench for the two-wire slave access block
`timescale 1ns/10ps
`include "resa_regs.svh"
module resa_slave_tb_top;
  localparam int CLK_DEPTH = 16;
  localparam int EE_WR_CYCLES = 2000;
  localparam int CEIL = 95000;
  localparam logic [3:0] DC = `RESA_DEV_CODE;
  logic mclk;
  logic sys_rst;
  logic scl;
  logic m_oe;
  logic s_oe;
  logic s_do;
  logic busy;
  wire logic sda;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;

  // open drain with pull-up
  assign sda = m_oe ? 1'b0 : (s_oe ? s_do : 1'b1);

  resa_slave #(.CLK_DEPTH(CLK_DEPTH), .EE_WR_CYCLES(EE_WR_CYCLES)) u_resa_slave (
    .MCLK_I(mclk), .SYS_RST_I(sys_rst), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(s_do), .SDA_OE_O(s_oe), .EE_BUSY_O(busy));

  // quarter bit of 16 clocks keeps every pin change just after a clock edge
  resa_i2c_master #(.Q_NS(640)) u_resa_i2c_master (
    .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic tally_and_finish();
    if (num_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] adr(input logic [2:0] blk, input logic rd);
    return {DC, blk, rd};
  endfunction : adr

  task automatic set_ptr(input logic [2:0] blk, input logic [7:0] w);
    logic a;
    u_resa_i2c_master.start();
    u_resa_i2c_master.wr_byte(adr(blk, 1'b0), a);
    chk({7'h00, a}, 8'h01);
    u_resa_i2c_master.wr_byte(w, a);
    chk({7'h00, a}, 8'h01);
  endtask : set_ptr

  task automatic open_rd(input logic [2:0] blk, input logic [7:0] w);
    logic a;
    set_ptr(blk, w);
    u_resa_i2c_master.rstart();
    u_resa_i2c_master.wr_byte(adr(blk, 1'b1), a);
    chk({7'h00, a}, 8'h01);
  endtask : open_rd

  task automatic wr_run(input logic [2:0] blk, input logic [7:0] w, input int n,
                        input logic [7:0] base);
    logic a;
    set_ptr(blk, w);
    for (int i = 0; i < n; i++) begin
      u_resa_i2c_master.wr_byte(base + i[7:0], a);
      chk({7'h00, a}, 8'h01);
    end
    u_resa_i2c_master.stop();
  endtask : wr_run

  task automatic rd_chk(input logic last, input logic [7:0] exp);
    logic [7:0] d;
    u_resa_i2c_master.rd_byte(last, d);
    chk(d, exp);
  endtask : rd_chk

  task automatic poll_done(input logic [2:0] blk);
    logic a;
    a = 1'b0;
    for (int i = 0; i < 10 && !a; i++) begin
      u_resa_i2c_master.start();
      u_resa_i2c_master.wr_byte(adr(blk, 1'b0), a);
      u_resa_i2c_master.stop();
    end
    chk({7'h00, a}, 8'h01);
  endtask : poll_done

  task automatic t_decode();
    logic a;
    for (int b = 3; b < 8; b++) begin
      u_resa_i2c_master.start();
      u_resa_i2c_master.wr_byte(adr(b[2:0], 1'b0), a);
      u_resa_i2c_master.stop();
      chk({7'h00, a}, 8'h00);
    end
    u_resa_i2c_master.start();
    u_resa_i2c_master.wr_byte({~DC, 4'h0}, a);
    u_resa_i2c_master.stop();
    chk({7'h00, a}, 8'h00);
    u_resa_i2c_master.start();
    u_resa_i2c_master.wr_byte(adr(3'h0, 1'b1), a);
    chk({7'h00, a}, 8'h01);
    rd_chk(1'b1, `RESA_CLK_RST);
    u_resa_i2c_master.stop();
  endtask : t_decode

  task automatic t_clock();
    wr_run(3'h0, 8'(CLK_DEPTH - 2), CLK_DEPTH + 2, 8'h40);
    chk({7'h00, busy}, 8'h00);
    open_rd(3'h0, 8'(CLK_DEPTH - 2));
    rd_chk(1'b0, 8'h50);
    rd_chk(1'b0, 8'h51);
    rd_chk(1'b0, 8'h42);
    rd_chk(1'b1, 8'h43);
    u_resa_i2c_master.stop();
  endtask : t_clock

  task automatic t_ee_page();
    logic a;
    wr_run(3'h1, 8'h0e, 10, 8'h60);
    repeat (8) @(posedge mclk);
    #1;
    chk({7'h00, busy}, 8'h01);
    u_resa_i2c_master.start();
    u_resa_i2c_master.wr_byte(adr(3'h1, 1'b0), a);
    u_resa_i2c_master.stop();
    chk({7'h00, a}, 8'h00);
    u_resa_i2c_master.start();
    u_resa_i2c_master.wr_byte(adr(3'h0, 1'b0), a);
    u_resa_i2c_master.stop();
    chk({7'h00, a}, 8'h01);
    chk({7'h00, busy}, 8'h01);
    poll_done(3'h1);
    open_rd(3'h1, 8'h08);
    for (int k = 0; k < 8; k++) begin
      rd_chk(1'b0, 8'h62 + k[7:0]);
    end
    rd_chk(1'b1, `RESA_EE_ERASED);
    u_resa_i2c_master.stop();
    wr_run(3'h1, 8'h0a, 1, 8'h11);
    poll_done(3'h1);
    open_rd(3'h1, 8'h09);
    rd_chk(1'b0, 8'h63);
    rd_chk(1'b0, 8'h11);
    rd_chk(1'b1, 8'h65);
    u_resa_i2c_master.stop();
  endtask : t_ee_page

  task automatic t_upper();
    logic a;
    wr_run(3'h2, 8'h00, 2, 8'h66);
    poll_done(3'h2);
    wr_run(3'h2, 8'hff, 1, 8'h77);
    poll_done(3'h2);
    open_rd(3'h2, 8'hff);
    rd_chk(1'b0, 8'h77);
    rd_chk(1'b1, 8'h66);
    u_resa_i2c_master.stop();
    u_resa_i2c_master.start();
    u_resa_i2c_master.wr_byte(adr(3'h2, 1'b1), a);
    chk({7'h00, a}, 8'h01);
    rd_chk(1'b1, 8'h67);
    u_resa_i2c_master.stop();
    open_rd(3'h1, 8'h00);
    rd_chk(1'b1, `RESA_EE_ERASED);
    u_resa_i2c_master.stop();
  endtask : t_upper

  initial begin
    sys_rst = 1'b1;
    repeat (20) @(posedge mclk);
    #1 sys_rst = 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    chk({6'h00, s_oe, busy}, 8'h00);
    t_decode();
    t_clock();
    t_ee_page();
    t_upper();
    tally_and_finish();
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      num_errors++;
      tally_and_finish();
    end
  end
endmodule : resa_slave_tb_top

// *** resa_strm_if.sv ***
// valid/ready stream between the slave modules
`timescale 1ns/10ps
interface resa_strm_if #(
  parameter int W = 19
) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : resa_strm_if
